// ### include/bbp_defs.svh
`ifndef BBP_DEFS_SVH
`define BBP_DEFS_SVH
// Image and page geometry.
`define BBP_IN_WORDS 4'h8
`define BBP_OUT_WORDS 4'h7
`define BBP_PAGE_WORDS 12'h006
`define BBP_PAGE_LAST 3'h5
`define BBP_LOAD_DONE 3'h6
`define BBP_PAGE_ROUND 12'h005
// Page codes carried in word 0.
`define BBP_CODE_FIRST 16'h0001
`define BBP_CODE_MAX 16'h029A
`define BBP_PAGES_MAX 12'h29A
`define BBP_CMD_BASE 16'h07D0
`define BBP_CMD_FIRST 16'h07D1
`define BBP_CMD_LAST 16'h07D6
`define BBP_WARM 16'h270E
`define BBP_COLD 16'h270F
// Database and command queue.
`define BBP_DB_WORDS 12'hFA0
`define BBP_Q_DEPTH 4'h8
// Register offsets (byte addresses).
`define BBP_OFF_WR_BASE 14'h0000
`define BBP_OFF_WR_COUNT 14'h0004
`define BBP_OFF_RD_BASE 14'h0008
`define BBP_OFF_RD_COUNT 14'h000C
`define BBP_OFF_CMD_LIMIT 14'h0010
`define BBP_OFF_PAGE_STAT 14'h0014
`define BBP_OFF_LAST_STAT 14'h0018
`define BBP_OFF_XFER_STAT 14'h001C
`define BBP_DB_WINDOW 2'h1
// Reset values.
`define BBP_RST_WR_BASE 12'h000
`define BBP_RST_WR_COUNT 12'h006
`define BBP_RST_RD_BASE 12'h000
`define BBP_RST_RD_COUNT 12'h006
`define BBP_RST_CMD_LIMIT 7'h64
// Bus responses.
`define BBP_RESP_OKAY 2'h0
`define BBP_RESP_SLVERR 2'h2
`endif

// ### include/bbp_pkg.sv
package bbp_pkg;
	typedef enum logic [2:0] {
		st_init = 3'h0,
		st_load = 3'h1,
		st_trig = 3'h3,
		st_fire = 3'h2,
		st_wait = 3'h6,
		st_store = 3'h7,
		st_next = 3'h5,
		st_cmd = 3'h4
	} bbp_state_e;
	typedef struct packed {
		logic [5:0][15:0] data;
		logic [15:0] code;
	} bbp_out_img_s;
	typedef struct packed {
		logic [5:0][15:0] data;
		logic [15:0] req;
		logic [15:0] code;
	} bbp_in_img_s;
	typedef struct packed {
		logic [11:0] wr_base;
		logic [11:0] wr_count;
		logic [11:0] rd_base;
		logic [11:0] rd_count;
		logic [6:0] cmd_limit;
	} bbp_cfg_s;
endpackage

// ### hw/bbp_mem.sv
`include "bbp_defs.svh"
module bbp_mem (
	input wire logic mclk,
	input wire logic a_en,
	input wire logic a_we,
	input wire logic [11:0] a_addr,
	input wire logic [15:0] a_wdata,
	output logic [15:0] a_rdata,
	input wire logic b_en,
	input wire logic b_we,
	input wire logic [1:0] b_be,
	input wire logic [11:0] b_addr,
	input wire logic [15:0] b_wdata,
	output logic [15:0] b_rdata
);
	logic [15:0] mem [4000];

	// Out-of-range addresses write nothing and read zero.
	always_ff @(posedge mclk) begin
		if (a_en && a_we && a_addr < `BBP_DB_WORDS)
			mem[a_addr] <= a_wdata;
		if (b_en && b_we && b_addr < `BBP_DB_WORDS) begin
			if (b_be[0])
				mem[b_addr][7:0] <= b_wdata[7:0];
			if (b_be[1])
				mem[b_addr][15:8] <= b_wdata[15:8];
		end
	end

	always_ff @(posedge mclk) begin
		if (a_en)
			a_rdata <= (a_addr < `BBP_DB_WORDS) ? mem[a_addr] : 16'h0000;
		if (b_en)
			b_rdata <= (b_addr < `BBP_DB_WORDS) ? mem[b_addr] : 16'h0000;
	end
endmodule

// ### hw/bbp_top.sv
// What this block does
// - Eight-word input, seven-word output image only.
// - Module writes input image, reads output image.
// - Every data page holds six words.
// - Input word 0 sent code, word 1 request.
// - Codes 0 to 666; zero page ignored.
// - Keep last code; word 0 change means new.
// - New read page when word 0 differs.
// - Init: codes one, last read code zero.
// - Load words 2-7, then word 1, word 0.
// - Store page at read base plus offset.
// - After read, pick next pages, send again.
// - Codes 2001-2006 give command count minus 2000.
// - Queue first count command indexes in order.
// - Queue regardless of enable, index must valid.
// - Answer echoes code, request, queued count.
// - Code 9998 warm restarts program state.
// - Code 9999 requests full hardware restart.
// - Queued commands run first, polling waits.
// - Restart clears status, restarts paging silently.
`include "bbp_defs.svh"
module bbp_top import bbp_pkg::*; (
	input wire logic mclk,
	input wire logic rst_n,
	input wire bbp_out_img_s out_img,
	output bbp_in_img_s in_img,
	output logic cmd_valid,
	output logic [6:0] cmd_index,
	input wire logic cmd_ready,
	output logic poll_hold,
	output logic hw_restart,
	input wire logic [15:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [15:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	bbp_out_img_s ob_s1, ob_s2, ob_s3, snap;
	bbp_state_e state;
	bbp_cfg_s cfg;
	logic [2:0] idx, n_cmd, queued;
	logic [15:0] wcode, rcode, last_rd, fire_code, cur_code;
	logic [15:0] wr_pages, rd_pages;
	logic [6:0] qmem [8];
	logic [2:0] q_wr, q_rd;
	logic [3:0] q_count;
	logic push, pop, new_page, wr_fire, rpend, rcap;
	logic a_en, a_we;
	logic [11:0] a_addr, wpages, rpages;
	logic [15:0] a_wdata, a_rdata, b_rdata, oc;
	logic [15:0] aw_a, ar_a;
	logic [31:0] w_d;
	logic [3:0] w_s;

	function automatic logic [11:0] pages(input logic [11:0] n);
		logic [11:0] p;
		p = 12'((n + `BBP_PAGE_ROUND) / `BBP_PAGE_WORDS);
		if (p == 12'h000)
			p = 12'h001;
		if (p > `BBP_PAGES_MAX)
			p = `BBP_PAGES_MAX;
		return p;
	endfunction

	function automatic logic [11:0] poff(input logic [15:0] code);
		logic [11:0] c;
		c = code[11:0] - 12'h001;
		return 12'((c << 2) + (c << 1));
	endfunction

	function automatic logic [15:0] merge(input logic [15:0] old,
		input logic [31:0] d, input logic [3:0] s);
		logic [15:0] m;
		m = old;
		if (s[0])
			m[7:0] = d[7:0];
		if (s[1])
			m[15:8] = d[15:8];
		return m;
	endfunction

	// The backplane image arrives from another clock, so it is retimed.
	// Word 0 must hold for two samples before it counts, since the bits
	// of a changing code may land on different edges.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ob_s1 <= '0;
			ob_s2 <= '0;
			ob_s3 <= '0;
		end else begin
			ob_s1 <= out_img;
			ob_s2 <= ob_s1;
			ob_s3 <= ob_s2;
		end
	end

	assign oc = ob_s3.code;
	assign new_page = state == st_wait && ob_s2.code == oc && oc != last_rd;
	assign wpages = pages(cfg.wr_count);
	assign rpages = pages(cfg.rd_count);

	always_comb begin
		a_en = 1'b0;
		a_we = 1'b0;
		a_addr = 12'h000;
		a_wdata = 16'h0000;
		if (state == st_load && idx < `BBP_LOAD_DONE) begin
			a_en = 1'b1;
			a_addr = 12'(cfg.wr_base + poff(wcode) + 12'(idx));
		end else if (state == st_store) begin
			a_en = 1'b1;
			a_we = 1'b1;
			a_addr = 12'(cfg.rd_base + poff(cur_code) + 12'(idx));
			a_wdata = snap.data[idx];
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state <= st_init;
			idx <= 3'h0;
			n_cmd <= 3'h0;
			queued <= 3'h0;
			wcode <= 16'h0000;
			rcode <= 16'h0000;
			last_rd <= 16'h0000;
			fire_code <= 16'h0000;
			cur_code <= 16'h0000;
			snap <= '0;
			in_img <= '0;
		end else begin
			unique case (state)
				st_init: begin
					wcode <= `BBP_CODE_FIRST;
					rcode <= `BBP_CODE_FIRST;
					last_rd <= 16'h0000;
					idx <= 3'h0;
					state <= st_load;
				end
				st_load: begin
					idx <= idx + 3'h1;
					if (idx != 3'h0)
						in_img.data[idx - 3'h1] <= a_rdata;
					if (idx == `BBP_LOAD_DONE) begin
						idx <= 3'h0;
						state <= st_trig;
					end
				end
				st_trig: begin
					in_img.req <= rcode;
					fire_code <= wcode;
					state <= st_fire;
				end
				st_fire: begin
					// Word 0 goes last so the host never sees a half page.
					in_img.code <= fire_code;
					state <= st_wait;
				end
				st_wait: begin
					if (new_page) begin
						snap <= ob_s3;
						cur_code <= oc;
						idx <= 3'h0;
						if (oc >= `BBP_CODE_FIRST && oc <= `BBP_CODE_MAX) begin
							state <= st_store;
						end else if (oc >= `BBP_CMD_FIRST &&
							oc <= `BBP_CMD_LAST) begin
							n_cmd <= 3'(oc - `BBP_CMD_BASE);
							queued <= 3'h0;
							last_rd <= oc;
							state <= st_cmd;
						end else if (oc == `BBP_WARM || oc == `BBP_COLD) begin
							state <= st_init;
						end else begin
							last_rd <= oc;
						end
					end
				end
				st_store: begin
					idx <= idx + 3'h1;
					if (idx == `BBP_PAGE_LAST) begin
						last_rd <= cur_code;
						state <= st_next;
					end
				end
				st_next: begin
					wcode <= (wcode >= {4'h0, wpages}) ? `BBP_CODE_FIRST :
						wcode + 16'h0001;
					rcode <= (rcode >= {4'h0, rpages}) ? `BBP_CODE_FIRST :
						rcode + 16'h0001;
					idx <= 3'h0;
					state <= st_load;
				end
				st_cmd: begin
					idx <= idx + 3'h1;
					queued <= queued + 3'(push);
					if (idx == `BBP_PAGE_LAST) begin
						in_img.req <= rcode;
						in_img.data <= '0;
						in_img.data[0] <= {13'h0000, 3'(queued + 3'(push))};
						fire_code <= cur_code;
						state <= st_fire;
					end
				end
			endcase
		end
	end

	// Commands that name no valid list entry are dropped, as are those
	// that find the queue full; the answer reports only what was queued.
	assign push = state == st_cmd && idx < n_cmd &&
		snap.data[idx] < {9'h000, cfg.cmd_limit} &&
		q_count < `BBP_Q_DEPTH;
	assign pop = (!cmd_valid || cmd_ready) && q_count != 4'h0;

	always_ff @(posedge mclk) begin
		if (push)
			qmem[q_wr] <= snap.data[idx][6:0];
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			q_wr <= 3'h0;
			q_rd <= 3'h0;
			q_count <= 4'h0;
			cmd_valid <= 1'b0;
			cmd_index <= 7'h00;
			poll_hold <= 1'b0;
		end else if (state == st_init) begin
			q_wr <= 3'h0;
			q_rd <= 3'h0;
			q_count <= 4'h0;
			cmd_valid <= 1'b0;
			poll_hold <= 1'b0;
		end else begin
			q_wr <= q_wr + 3'(push);
			q_rd <= q_rd + 3'(pop);
			q_count <= q_count + 4'(push) - 4'(pop);
			if (pop) begin
				cmd_valid <= 1'b1;
				cmd_index <= qmem[q_rd];
			end else if (cmd_ready) begin
				cmd_valid <= 1'b0;
			end
			poll_hold <= cmd_valid || q_count != 4'h0 || push;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			hw_restart <= 1'b0;
			wr_pages <= 16'h0000;
			rd_pages <= 16'h0000;
		end else begin
			hw_restart <= new_page && oc == `BBP_COLD;
			if (state == st_init) begin
				wr_pages <= 16'h0000;
				rd_pages <= 16'h0000;
			end else begin
				wr_pages <= wr_pages + 16'(state == st_trig);
				rd_pages <= rd_pages + 16'(state == st_next);
			end
		end
	end

	// Register bus: address and data are held until both are in, and a
	// write waits while a read owns the database port.
	assign wr_fire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid &&
		!rpend;

	bbp_mem u_bbp_mem (
		.mclk(mclk),
		.a_en(a_en),
		.a_we(a_we),
		.a_addr(a_addr),
		.a_wdata(a_wdata),
		.a_rdata(a_rdata),
		.b_en(rpend || wr_fire),
		.b_we(wr_fire && aw_a[15:14] == `BBP_DB_WINDOW),
		.b_be(w_s[1:0]),
		.b_addr(wr_fire ? aw_a[13:2] : ar_a[13:2]),
		.b_wdata(w_d[15:0]),
		.b_rdata(b_rdata)
	);

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `BBP_RESP_OKAY;
			aw_a <= 16'h0000;
			w_d <= 32'h0000_0000;
			w_s <= 4'h0;
			cfg <= {`BBP_RST_WR_BASE, `BBP_RST_WR_COUNT, `BBP_RST_RD_BASE,
				`BBP_RST_RD_COUNT, `BBP_RST_CMD_LIMIT};
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_a <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_d <= s_axi_wdata;
				w_s <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
			if (wr_fire) begin
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= `BBP_RESP_OKAY;
				if (aw_a[15:14] == `BBP_DB_WINDOW) begin
					if (aw_a[13:2] >= `BBP_DB_WORDS)
						s_axi_bresp <= `BBP_RESP_SLVERR;
				end else if (aw_a[15:14] != 2'h0) begin
					s_axi_bresp <= `BBP_RESP_SLVERR;
				end else begin
					unique case ({aw_a[13:2], 2'h0})
						`BBP_OFF_WR_BASE:
							cfg.wr_base <= 12'(merge({4'h0, cfg.wr_base}, w_d, w_s));
						`BBP_OFF_WR_COUNT:
							cfg.wr_count <= 12'(merge({4'h0, cfg.wr_count}, w_d, w_s));
						`BBP_OFF_RD_BASE:
							cfg.rd_base <= 12'(merge({4'h0, cfg.rd_base}, w_d, w_s));
						`BBP_OFF_RD_COUNT:
							cfg.rd_count <= 12'(merge({4'h0, cfg.rd_count}, w_d, w_s));
						`BBP_OFF_CMD_LIMIT:
							cfg.cmd_limit <= 7'(merge({9'h000, cfg.cmd_limit}, w_d, w_s));
						`BBP_OFF_PAGE_STAT, `BBP_OFF_LAST_STAT,
						`BBP_OFF_XFER_STAT: ;
						default: s_axi_bresp <= `BBP_RESP_SLVERR;
					endcase
				end
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `BBP_RESP_OKAY;
			ar_a <= 16'h0000;
			rpend <= 1'b0;
			rcap <= 1'b0;
		end else begin
			rpend <= s_axi_arvalid && s_axi_arready;
			rcap <= rpend;
			if (s_axi_arvalid && s_axi_arready) begin
				ar_a <= s_axi_araddr;
				s_axi_arready <= 1'b0;
			end
			if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end
			if (rcap) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= `BBP_RESP_OKAY;
				s_axi_rdata <= 32'h0000_0000;
				if (ar_a[15:14] == `BBP_DB_WINDOW) begin
					s_axi_rdata <= {16'h0000, b_rdata};
					if (ar_a[13:2] >= `BBP_DB_WORDS)
						s_axi_rresp <= `BBP_RESP_SLVERR;
				end else if (ar_a[15:14] != 2'h0) begin
					s_axi_rresp <= `BBP_RESP_SLVERR;
				end else begin
					unique case ({ar_a[13:2], 2'h0})
						`BBP_OFF_WR_BASE: s_axi_rdata[11:0] <= cfg.wr_base;
						`BBP_OFF_WR_COUNT: s_axi_rdata[11:0] <= cfg.wr_count;
						`BBP_OFF_RD_BASE: s_axi_rdata[11:0] <= cfg.rd_base;
						`BBP_OFF_RD_COUNT: s_axi_rdata[11:0] <= cfg.rd_count;
						`BBP_OFF_CMD_LIMIT: s_axi_rdata[6:0] <= cfg.cmd_limit;
						`BBP_OFF_PAGE_STAT: s_axi_rdata <= {rcode, wcode};
						`BBP_OFF_LAST_STAT:
							s_axi_rdata <= {11'h000, poll_hold, q_count, last_rd};
						`BBP_OFF_XFER_STAT: s_axi_rdata <= {rd_pages, wr_pages};
						default: s_axi_rresp <= `BBP_RESP_SLVERR;
					endcase
				end
			end
		end
	end
endmodule

// ### sim/bbp_top_asserts.sv
module bbp_top_chk import bbp_pkg::*; (
	input wire logic mclk,
	input wire logic rst_n,
	input wire bbp_out_img_s out_img,
	input wire bbp_in_img_s in_img,
	input wire logic cmd_valid,
	input wire logic [6:0] cmd_index,
	input wire logic cmd_ready,
	input wire logic poll_hold,
	input wire logic hw_restart
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	sequence s_fire;
		$changed(in_img.code) ##0 in_img.code inside {[16'h0001:16'h029A]};
	endsequence
	sequence s_cmd_fire;
		$changed(in_img.code) ##0 in_img.code inside {[16'h07D1:16'h07D6]};
	endsequence
	a_init_codes: assert property ($rose(rst_n) |-> ##[1:40]
		(in_img.code == 16'h0001 && in_img.req == 16'h0001))
		else $error("first page codes are not one");
	a_word0_last: assert property (s_fire |->
		$stable(in_img.req) && $stable(in_img.data))
		else $error("page code moved with its payload");
	a_req_range: assert property (s_fire |->
		in_img.req inside {[16'h0001:16'h029A]})
		else $error("requested page out of range");
	a_code_range: assert property (
		in_img.code inside {[16'h0000:16'h029A], [16'h07D1:16'h07D6]})
		else $error("illegal outgoing page code");
	a_cmd_echo: assert property (s_cmd_fire |-> in_img.data[5:1] == '0
		&& in_img.data[0] <= in_img.code - 16'h07D0)
		else $error("bad command page answer");
	a_cmd_hold: assert property (cmd_valid && !cmd_ready |=>
		cmd_valid && $stable(cmd_index))
		else $error("command dropped before taken");
	a_poll_wait: assert property (cmd_valid |-> poll_hold)
		else $error("polling not held with queue busy");
	a_cold_pulse: assert property (hw_restart |=> !hw_restart)
		else $error("restart pulse too long");
	a_cold_cause: assert property (hw_restart |-> out_img.code == 16'h270F
		&& $past(out_img.code, 3) == 16'h270F)
		else $error("restart without its code");
endmodule
bind bbp_top bbp_top_chk u_bbp_top_chk (.mclk(mclk), .rst_n(rst_n),
	.out_img(out_img), .in_img(in_img), .cmd_valid(cmd_valid),
	.cmd_index(cmd_index), .cmd_ready(cmd_ready), .poll_hold(poll_hold),
	.hw_restart(hw_restart));

// ### sim/bbp_host.sv
module bbp_host import bbp_pkg::*; (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic en,
	input wire logic slow,
	input wire logic ovr,
	input wire bbp_out_img_s ovr_img,
	input wire bbp_in_img_s in_img,
	output bbp_out_img_s out_img,
	output logic [7:0] pages
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [15:0] wfile [0:3995];
	logic [15:0] last_wr;
	logic [15:0] pend;
	logic [4:0] dly;
	logic arm;
	bbp_out_img_s own;
	// A slow answer keeps the payload standing while the code waits.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			own <= '0;
			last_wr <= '0;
			arm <= 1'b0;
			pages <= '0;
		end else if (arm) begin
			dly <= dly - 5'h1;
			if (dly == 5'h0) begin
				own.code <= pend;
				arm <= 1'b0;
			end
		end else if (en && in_img.code != last_wr &&
			in_img.code inside {[16'h0001:16'h029A]}) begin
			for (int k = 0; k < 6; k++) begin
				wfile[(in_img.code - 16'h1) * 6 + k] <= in_img.data[k];
				own.data[k] <= 16'hA000 + (in_img.req - 16'h1) * 6 + 16'(k);
			end
			last_wr <= in_img.code;
			pend <= in_img.req;
			dly <= slow ? 5'h14 : 5'h0;
			arm <= 1'b1;
			pages <= pages + 8'h1;
		end
	end
	assign out_img = ovr ? ovr_img : own;
endmodule

// ### sim/bbp_tb_top.sv
module bbp_tb_top import bbp_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic cmd_ready = 1'b0, en = 1'b0, slow = 1'b0, ovr = 1'b0;
	logic cmd_valid, poll_hold, hw_restart;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [15:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [31:0] s_axi_wdata = '0;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic [6:0] cmd_index;
	logic [7:0] pages;
	logic [15:0] wexp [0:11];
	logic [15:0] idx;
	logic [33:0] e;
	bbp_out_img_s out_img;
	bbp_out_img_s ovr_img = '0;
	bbp_in_img_s in_img;
	logic [33:0] rq [$];
	logic [6:0] cq [$];
	int err_count = 0, samples_checked = 0, cyc = 0, q;
	bbp_top u_bbp_top (.mclk(mclk), .rst_n(rst_n), .out_img(out_img),
		.in_img(in_img), .cmd_valid(cmd_valid), .cmd_index(cmd_index),
		.cmd_ready(cmd_ready), .poll_hold(poll_hold), .hw_restart(hw_restart),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready));
	bbp_host u_bbp_host (.mclk(mclk), .rst_n(rst_n), .en(en), .slow(slow),
		.ovr(ovr), .ovr_img(ovr_img), .in_img(in_img), .out_img(out_img),
		.pages(pages));
	always #12.5 mclk = ~mclk;
	task automatic conclude();
		$display("mismatches %0d checks %0d", err_count, samples_checked);
		if (err_count == 0 && samples_checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [33:0] g, input logic [33:0] x);
		samples_checked++;
		if (g !== x) begin
			err_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, x);
		end
	endtask
	task automatic axw(input logic [15:0] a, input logic [31:0] d);
		logic aw;
		logic w;
		aw = 1'b1;
		w = 1'b1;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge mclk);
			if (aw && s_axi_awready) begin
				aw = 1'b0;
				s_axi_awvalid <= 1'b0;
			end
			if (w && s_axi_wready) begin
				w = 1'b0;
				s_axi_wvalid <= 1'b0;
			end
		end while (aw || w || !s_axi_bvalid);
		chk({32'h0, s_axi_bresp}, 34'h0);
		s_axi_bready <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic axr(input logic [15:0] a, input logic [33:0] x);
		logic ar;
		ar = 1'b1;
		rq.push_back(x);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge mclk);
			if (ar && s_axi_arready) begin
				ar = 1'b0;
				s_axi_arvalid <= 1'b0;
			end
		end while (ar || !s_axi_rvalid);
		s_axi_rready <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic wait_code(input logic [15:0] c);
		for (int n = 0; n < 400 && in_img.code !== c; n++) @(posedge mclk);
		chk({18'h0, in_img.code}, {18'h0, c});
	endtask
	// Results are compared when they appear, against notes in order.
	always @(posedge mclk) begin
		if (s_axi_rvalid && s_axi_rready) begin
			e = rq.size() > 0 ? rq.pop_front() : '1;
			chk({s_axi_rresp, e[33:32] == 2'h0 ? s_axi_rdata : 32'h0}, e);
		end
		if (cmd_valid && cmd_ready) begin
			chk({27'h0, cmd_index}, {27'h0, cq.size() > 0 ? cq.pop_front() : 7'h7F});
		end
	end
	always @(posedge mclk) begin
		cmd_ready <= 1'($urandom);
		slow <= 1'($urandom);
		cyc++;
		if (cyc == 20000) begin
			err_count++;
			conclude();
		end
	end
	initial begin
		void'($urandom(76444));
		repeat (12) @(posedge mclk);
		rst_n <= 1'b1;
		wait_code(16'h0001);
		chk({18'h0, in_img.req}, {18'h0, 16'h0001});
		axr(16'h0014, {2'h0, 32'h0001_0001});
		axr(16'h0018, {2'h0, 32'h0000_0000});
		axr(16'h0004, {2'h0, 32'h0000_0006});
		axr(16'h0100, {2'h2, 32'h0000_0000});
		axw(16'h0000, 32'h0000_00C8);
		axw(16'h0004, 32'h0000_000C);
		axw(16'h0008, 32'h0000_0064);
		axw(16'h000C, 32'h0000_000C);
		for (int i = 0; i < 12; i++) begin
			wexp[i] = 16'($urandom);
			axw(16'h4000 + 16'(4 * (200 + i)), {16'h0, wexp[i]});
		end
		en <= 1'b1;
		for (int n = 0; n < 3000 && pages < 8'h6; n++) @(posedge mclk);
		en <= 1'b0;
		ovr <= 1'b1;
		for (int i = 0; i < 12; i++) begin
			chk({18'h0, u_bbp_host.wfile[i]}, {18'h0, wexp[i]});
			axr(16'h4000 + 16'(4 * (100 + i)), {18'h0, 16'hA000 + 16'(i)});
		end
		repeat (40) @(posedge mclk);
		for (int n = 1; n <= 6; n++) begin
			q = 0;
			for (int j = 0; j < 6; j++) begin
				idx = (j == 1) ? 16'h0096 : 16'($urandom_range(0, 99));
				ovr_img.data[j] <= idx;
				if (j < n && j != 1) begin
					cq.push_back(idx[6:0]);
					q++;
				end
			end
			@(posedge mclk);
			ovr_img.code <= 16'h07D0 + 16'(n);
			wait_code(16'h07D0 + 16'(n));
			chk({18'h0, in_img.data[0]}, 34'(q));
		end
		for (int n = 0; n < 400 && cq.size() > 0; n++) @(posedge mclk);
		chk(34'(cq.size()), 34'h0);
		ovr_img.code <= 16'h270E;
		// The restart code must be withdrawn before paging resumes, since
		// init zeroes the last read code and would see it again.
		repeat (6) @(posedge mclk);
		ovr_img.code <= 16'h0000;
		wait_code(16'h0001);
		axr(16'h001C, {2'h0, 32'h0000_0001});
		axr(16'h0014, {2'h0, 32'h0001_0001});
		axr(16'h0018, {2'h0, 32'h0000_0000});
		axr(16'h0004, {2'h0, 32'h0000_000C});
		ovr_img.code <= 16'h270F;
		for (int n = 0; n < 100 && hw_restart !== 1'b1; n++) @(posedge mclk);
		chk({33'h0, hw_restart}, {33'h0, 1'b1});
		repeat (4) @(posedge mclk);
		conclude();
	end
endmodule
